// ### hdl/cbc_pkg.sv
package cbc_pkg;

    // Register addresses within the CPU register space
    localparam logic [4:0] CBC_R0  = 5'h00;
    localparam logic [4:0] CBC_R3  = 5'h03;
    localparam logic [4:0] CBC_R4  = 5'h04;
    localparam logic [4:0] CBC_R7  = 5'h07;
    localparam logic [4:0] CBC_R8  = 5'h08;
    localparam logic [4:0] CBC_R11 = 5'h0B;

    // Alternate bank A slots of the configuration registers
    localparam logic [1:0] CBC_SLOT_DEVICE_CONTROL    = 2'h0;
    localparam logic [1:0] CBC_SLOT_VECTOR_PAGE_BASE  = 2'h1;
    localparam logic [1:0] CBC_SLOT_INTERRUPT_MASK    = 2'h2;
    localparam logic [1:0] CBC_SLOT_AUXILIARY_CONTROL = 2'h3;
    // Main bank A slot that shows transceiver status
    localparam logic [1:0] CBC_SLOT_XCVR_STATUS       = 2'h0;

    // Reset values
    localparam logic [7:0] CBC_DEVICE_CONTROL_RESET    = 8'h1F;
    localparam logic [7:0] CBC_AUXILIARY_CONTROL_RESET = 8'h00;
    localparam logic [7:0] CBC_VECTOR_PAGE_BASE_RESET  = 8'h00;
    localparam logic [7:0] CBC_INTERRUPT_MASK_RESET    = 8'h00;
    localparam logic [7:0] CBC_NMI_VECTOR_OFFSET       = 8'h1C;

    // Bank exchange length in T-states
    localparam logic [1:0] CBC_EXX_TSTATES = 2'h2;

    // Clock rates
    localparam int CBC_OSC_FREQ_HZ = 40_000_000;
    localparam int CBC_OSC_PERIOD_NS = 1_000_000_000 / CBC_OSC_FREQ_HZ;

    // Transceiver clock select encodings
    localparam logic [1:0] CBC_XCLK_OSC      = 2'h0;
    localparam logic [1:0] CBC_XCLK_OSC_DIV2 = 2'h1;
    localparam logic [1:0] CBC_XCLK_OSC_DIV4 = 2'h2;
    localparam logic [1:0] CBC_XCLK_EXTERNAL = 2'h3;

    // Interrupt mask index shared with the bidirectional pin
    localparam int CBC_SHARED_PIN_SOURCE = 3;
    localparam int CBC_NUM_SOURCES = 5;

    typedef struct packed {
        logic       cpu_clock_halve_select;
        logic [1:0] xcvr_clock_select;
        logic [1:0] instr_wait_field;
        logic [2:0] data_wait_field;
    } cbc_device_control_t;

    typedef struct packed {
        logic [4:0] spare;
        logic       bidir_pin_direction;
        logic       clock_out_disable;
        logic       global_irq_enable;
    } cbc_auxiliary_control_t;

    typedef struct packed {
        logic [2:0] spare;
        logic [4:0] per_source_masks;
    } cbc_interrupt_mask_t;

    typedef struct packed {
        logic a_alt;
        logic b_alt;
    } cbc_bank_sel_t;

    // Interrupt enable action of a bank exchange
    typedef enum logic [1:0] {
        CBC_GIE_KEEP  = 2'b00,
        CBC_GIE_SET   = 2'b01,
        CBC_GIE_CLEAR = 2'b10
    } cbc_gie_op_t;

    typedef struct packed {
        cbc_bank_sel_t banks;
        cbc_gie_op_t   gie_op;
    } cbc_exx_cmd_t;

endpackage

// ### hdl/cbc_clock_gen.sv
`timescale 1ns/1ps
module cbc_clock_gen
    import cbc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Settings
    input  wire logic       cpu_clock_halve_select,
    input  wire logic [1:0] xcvr_clock_select,
    // External transceiver clock pin
    input  wire logic       external_xcvr_clock_in,
    // Enables
    output logic            cpu_tstate_en,
    output logic            xcvr_clock_en
);

    logic [1:0] div;
    logic [1:0] next_div;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_last;

    always_comb begin
        next_div = div + 2'h1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div      <= 2'h0;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_last <= 1'b0;
        end else begin
            div      <= next_div;
            ext_meta <= external_xcvr_clock_in;
            ext_sync <= ext_meta;
            ext_last <= ext_sync;
        end
    end

    assign cpu_tstate_en = cpu_clock_halve_select ? div[0] : 1'b1;

    always_comb begin
        case (xcvr_clock_select)
            CBC_XCLK_OSC:      xcvr_clock_en = 1'b1;
            CBC_XCLK_OSC_DIV2: xcvr_clock_en = div[0];
            CBC_XCLK_OSC_DIV4: xcvr_clock_en = &div;
            default:           xcvr_clock_en = ext_sync & ~ext_last;
        endcase
    end

endmodule // cbc_clock_gen

// ### hdl/cbc_irq_gate.sv
`timescale 1ns/1ps
module cbc_irq_gate
    import cbc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Settings
    input  wire logic       global_irq_enable,
    input  wire logic [4:0] per_source_masks,
    input  wire logic       bidir_pin_direction,
    // Sources
    input  wire logic [4:0] irq_sources,
    input  wire logic       bidir_irq_pin_i,
    // Pin drive
    output logic            bidir_irq_pin_o,
    output logic            bidir_irq_pin_oe,
    // Result
    output logic            irq_request,
    output logic [2:0]      irq_source_id
);

    logic       pin_meta;
    logic       pin_sync;
    logic [4:0] live;
    logic [4:0] permitted;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= bidir_irq_pin_i;
            pin_sync <= pin_meta;
        end
    end

    // Pin request as source three when input
    always_comb begin
        live = irq_sources;
        live[CBC_SHARED_PIN_SOURCE] = bidir_pin_direction ? 1'b0 : ~pin_sync;
    end

    assign permitted   = live & per_source_masks;
    assign irq_request = global_irq_enable & (|permitted);

    always_comb begin
        irq_source_id = 3'h0;
        for (int i = CBC_NUM_SOURCES - 1; i >= 0; i--) begin
            if (permitted[i]) begin
                irq_source_id = 3'(i);
            end
        end
    end

    assign bidir_irq_pin_oe = bidir_pin_direction;
    assign bidir_irq_pin_o  = per_source_masks[CBC_SHARED_PIN_SOURCE];

endmodule // cbc_irq_gate

// ### hdl/cbc_config_top.sv
`timescale 1ns/1ps
module cbc_config_top
    import cbc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // CPU register port
    input  wire logic [4:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    output logic            reg_hit,
    // Bank exchange instruction
    input  wire logic       exx_req,
    input  wire logic       exx_a_alt,
    input  wire logic       exx_b_alt,
    input  wire logic [1:0] exx_gie_op,
    output logic            exx_busy,
    output logic            exx_done,
    output logic            bank_a_alt,
    output logic            bank_b_alt,
    // Transceiver access through alternate bank B; status flags read in main bank A and drive the jump test flags
    input  wire logic [7:0] xcvr_status_flags,
    input  wire logic [7:0] xcvr_rdata,
    output logic            xcvr_wr,
    output logic            xcvr_rd,
    output logic [1:0]      xcvr_index,
    output logic [7:0]      xcvr_wdata,
    output logic [7:0]      jump_test_flags,
    // Clocks
    input  wire logic       external_xcvr_clock_in,
    output logic            cpu_tstate_en,
    output logic            xcvr_clock_en,
    output logic            clock_out_o,
    output logic            clock_out_oe,
    // Memory timing
    output logic [1:0]      instr_wait_count,
    output logic [2:0]      data_wait_count,
    // Interrupts
    input  wire logic [4:0] irq_sources,
    input  wire logic [7:0] vector_offset,
    output logic [15:0]     vector_address,
    output logic            irq_request,
    output logic [2:0]      irq_source_id,
    input  wire logic       bidir_irq_pin_i,
    output logic            bidir_irq_pin_o,
    output logic            bidir_irq_pin_oe
);

    typedef enum logic [1:0] {
        CBC_EXX_IDLE = 2'b01,
        CBC_EXX_RUN  = 2'b10
    } cbc_exx_state_t;

    cbc_device_control_t    device_control;
    cbc_auxiliary_control_t auxiliary_control;
    logic [7:0]             vector_page_base;
    cbc_interrupt_mask_t    interrupt_mask_control;
    cbc_bank_sel_t          banks;
    cbc_exx_state_t         exx_state;
    cbc_exx_cmd_t           exx_cmd;
    logic [1:0]             exx_count;
    logic [7:0]             ctrl_regs [1:3];
    logic [7:0]             gp_regs [0:11];

    cbc_device_control_t    next_device_control;
    cbc_auxiliary_control_t next_auxiliary_control;
    logic [7:0]             next_vector_page_base;
    cbc_interrupt_mask_t    next_interrupt_mask_control;
    cbc_bank_sel_t          next_banks;
    cbc_exx_state_t         next_exx_state;
    cbc_exx_cmd_t           next_exx_cmd;
    logic [1:0]             next_exx_count;
    logic [7:0]             next_ctrl_regs [1:3];
    logic [7:0]             next_gp_regs [0:11];
    logic [7:0]             next_reg_rdata;
    logic                   next_reg_hit;
    logic                   exx_finish;

    // Index into the twelve general registers: main B uses 0-7, alternate B 8-11
    function automatic logic [3:0] gp_slot(input logic [4:0] addr, input logic b_alt);
        logic [3:0] slot;
        slot = addr[3:0] - 4'h4;
        if (b_alt) begin
            slot = 4'h8 + (addr[3:0] - 4'h8);
        end
        return slot;
    endfunction

    function automatic logic in_range(input logic [4:0] addr, input logic [4:0] lo, input logic [4:0] hi);
        return (addr >= lo) && (addr <= hi);
    endfunction

    cbc_clock_gen u_clock_gen (
        .clk                    (clk),
        .reset_n                (reset_n),
        .cpu_clock_halve_select (device_control.cpu_clock_halve_select),
        .xcvr_clock_select      (device_control.xcvr_clock_select),
        .external_xcvr_clock_in (external_xcvr_clock_in),
        .cpu_tstate_en          (cpu_tstate_en),
        .xcvr_clock_en          (xcvr_clock_en)
    );

    cbc_irq_gate u_irq_gate (
        .clk                 (clk),
        .reset_n             (reset_n),
        .global_irq_enable   (auxiliary_control.global_irq_enable),
        .per_source_masks    (interrupt_mask_control.per_source_masks),
        .bidir_pin_direction (auxiliary_control.bidir_pin_direction),
        .irq_sources         (irq_sources),
        .bidir_irq_pin_i     (bidir_irq_pin_i),
        .bidir_irq_pin_o     (bidir_irq_pin_o),
        .bidir_irq_pin_oe    (bidir_irq_pin_oe),
        .irq_request         (irq_request),
        .irq_source_id       (irq_source_id)
    );

    assign exx_finish = (exx_state == CBC_EXX_RUN) && cpu_tstate_en && (exx_count == CBC_EXX_TSTATES - 2'h1);

    always_comb begin
        next_exx_state = exx_state;
        next_exx_cmd   = exx_cmd;
        next_exx_count = exx_count;
        next_banks     = banks;
        case (exx_state)
            CBC_EXX_IDLE: begin
                if (exx_req) begin
                    next_exx_state = CBC_EXX_RUN;
                    next_exx_cmd   = {exx_a_alt, exx_b_alt, cbc_gie_op_t'(exx_gie_op)};
                    next_exx_count = 2'h0;
                end
            end
            CBC_EXX_RUN: begin
                if (exx_finish) begin
                    next_banks     = exx_cmd.banks;
                    next_exx_state = CBC_EXX_IDLE;
                end else if (cpu_tstate_en) begin
                    next_exx_count = exx_count + 2'h1;
                end
            end
            default: next_exx_state = CBC_EXX_IDLE;
        endcase
    end

    assign exx_busy   = (exx_state == CBC_EXX_RUN);
    assign exx_done   = exx_finish;
    assign bank_a_alt = banks.a_alt;
    assign bank_b_alt = banks.b_alt;

    // Register writes and reads
    always_comb begin
        next_device_control         = device_control;
        next_auxiliary_control      = auxiliary_control;
        next_vector_page_base       = vector_page_base;
        next_interrupt_mask_control = interrupt_mask_control;
        next_ctrl_regs              = ctrl_regs;
        next_gp_regs                = gp_regs;
        next_reg_rdata              = reg_rdata;
        next_reg_hit                = 1'b0;
        xcvr_wr                     = 1'b0;
        xcvr_rd                     = 1'b0;
        if (in_range(reg_addr, CBC_R0, CBC_R3)) begin
            if (banks.a_alt) begin
                if (reg_wr) begin
                    if (reg_addr[1:0] == CBC_SLOT_DEVICE_CONTROL) begin
                        next_device_control = cbc_device_control_t'(reg_wdata);
                    end else if (reg_addr[1:0] == CBC_SLOT_VECTOR_PAGE_BASE) begin
                        next_vector_page_base = reg_wdata;
                    end else if (reg_addr[1:0] == CBC_SLOT_INTERRUPT_MASK) begin
                        next_interrupt_mask_control = cbc_interrupt_mask_t'(reg_wdata);
                    end else begin
                        next_auxiliary_control = cbc_auxiliary_control_t'(reg_wdata);
                    end
                end
            end else if (reg_wr && reg_addr[1:0] != CBC_SLOT_XCVR_STATUS) begin
                next_ctrl_regs[reg_addr[1:0]] = reg_wdata;
            end
            if (reg_rd) begin
                next_reg_hit = 1'b1;
                if (banks.a_alt) begin
                    if (reg_addr[1:0] == CBC_SLOT_DEVICE_CONTROL) begin
                        next_reg_rdata = device_control;
                    end else if (reg_addr[1:0] == CBC_SLOT_VECTOR_PAGE_BASE) begin
                        next_reg_rdata = vector_page_base;
                    end else if (reg_addr[1:0] == CBC_SLOT_INTERRUPT_MASK) begin
                        next_reg_rdata = interrupt_mask_control;
                    end else begin
                        next_reg_rdata = auxiliary_control;
                    end
                end else if (reg_addr[1:0] == CBC_SLOT_XCVR_STATUS) begin
                    // Status visible in main bank A
                    next_reg_rdata = xcvr_status_flags;
                end else begin
                    next_reg_rdata = ctrl_regs[reg_addr[1:0]];
                end
            end
        end else if (banks.b_alt && in_range(reg_addr, CBC_R4, CBC_R7)) begin
            xcvr_wr = reg_wr;
            xcvr_rd = reg_rd;
            if (reg_rd) begin
                next_reg_hit   = 1'b1;
                next_reg_rdata = xcvr_rdata;
            end
        end else if (in_range(reg_addr, CBC_R4, CBC_R11)) begin
            if (reg_wr) begin
                next_gp_regs[gp_slot(reg_addr, banks.b_alt)] = reg_wdata;
            end
            if (reg_rd) begin
                next_reg_hit   = 1'b1;
                next_reg_rdata = gp_regs[gp_slot(reg_addr, banks.b_alt)];
            end
        end
        if (exx_finish && exx_cmd.gie_op == CBC_GIE_SET) begin
            next_auxiliary_control.global_irq_enable = 1'b1;
        end else if (exx_finish && exx_cmd.gie_op == CBC_GIE_CLEAR) begin
            next_auxiliary_control.global_irq_enable = 1'b0;
        end
    end

    assign xcvr_index = reg_addr[1:0];
    assign xcvr_wdata = reg_wdata;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            banks     <= '{a_alt: 1'b1, b_alt: 1'b1};
            exx_state <= CBC_EXX_IDLE;
            exx_cmd   <= '0;
            exx_count <= 2'h0;
            device_control         <= cbc_device_control_t'(CBC_DEVICE_CONTROL_RESET);
            auxiliary_control      <= cbc_auxiliary_control_t'(CBC_AUXILIARY_CONTROL_RESET);
            vector_page_base       <= CBC_VECTOR_PAGE_BASE_RESET;
            interrupt_mask_control <= cbc_interrupt_mask_t'(CBC_INTERRUPT_MASK_RESET);
            for (int i = 1; i <= 3; i++) begin
                ctrl_regs[i] <= 8'h00;
            end
            for (int i = 0; i < 12; i++) begin
                gp_regs[i] <= 8'h00;
            end
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end else begin
            banks                  <= next_banks;
            exx_state              <= next_exx_state;
            exx_cmd                <= next_exx_cmd;
            exx_count              <= next_exx_count;
            device_control         <= next_device_control;
            auxiliary_control      <= next_auxiliary_control;
            vector_page_base       <= next_vector_page_base;
            interrupt_mask_control <= next_interrupt_mask_control;
            ctrl_regs              <= next_ctrl_regs;
            gp_regs                <= next_gp_regs;
            reg_rdata              <= next_reg_rdata;
            reg_hit                <= next_reg_hit;
        end
    end

    assign jump_test_flags = xcvr_status_flags;

    assign instr_wait_count = device_control.instr_wait_field;
    assign data_wait_count  = device_control.data_wait_field;

    assign vector_address = {vector_page_base, vector_offset};

    // Undivided oscillator on the pin; clock gating is avoided, the clock is only forwarded
    assign clock_out_o  = clk;
    assign clock_out_oe = ~auxiliary_control.clock_out_disable;

endmodule // cbc_config_top

// ### dv/cbc_config_sva.sv
`timescale 1ns/1ps
module cbc_config_sva
    import cbc_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register port
    input wire logic [4:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_hit,
    input wire logic [7:0]  reg_wdata,
    // Bank exchange
    input wire logic        exx_req,
    input wire logic        exx_busy,
    input wire logic        exx_done,
    input wire logic        bank_a_alt,
    input wire logic        bank_b_alt,
    // Transceiver and pins
    input wire logic [7:0]  xcvr_status_flags,
    input wire logic [7:0]  jump_test_flags,
    input wire logic        xcvr_wr,
    input wire logic        xcvr_rd,
    input wire logic [1:0]  xcvr_index,
    input wire logic [7:0]  xcvr_wdata,
    input wire logic        clock_out_oe,
    input wire logic        bidir_irq_pin_oe,
    // Interrupts
    input wire logic [4:0]  irq_sources,
    input wire logic        irq_request,
    input wire logic [7:0]  vector_offset,
    input wire logic [15:0] vector_address
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    exx_length_a: assert property (exx_req && !exx_busy |=> exx_busy ##[0:4] exx_done)
        else $error("bank exchange did not finish in time");
    exx_pulse_a: assert property (exx_done |=> !exx_done && !exx_busy)
        else $error("bank exchange done too long");
    bank_hold_a: assert property (!exx_done |=> $stable({bank_a_alt, bank_b_alt}))
        else $error("bank changed without exchange");
    reset_state_a: assert property ($rose(reset_n) |-> bank_a_alt && bank_b_alt && clock_out_oe)
        else $error("wrong state after reset");
    read_hit_a: assert property (reg_rd |=> reg_hit == ($past(reg_addr) <= 5'h0B))
        else $error("read hit wrong");
    no_hit_a: assert property (!reg_rd |=> !reg_hit)
        else $error("hit without read");
    xcvr_strobe_a: assert property (xcvr_wr == (reg_wr && bank_b_alt && reg_addr inside {[5'h04:5'h07]}))
        else $error("transceiver write strobe wrong");
    xcvr_read_a: assert property (xcvr_rd == (reg_rd && bank_b_alt && reg_addr inside {[5'h04:5'h07]}))
        else $error("transceiver read strobe wrong");
    xcvr_path_a: assert property (xcvr_index == reg_addr[1:0] && xcvr_wdata == reg_wdata)
        else $error("transceiver index or data wrong");
    jump_flags_a: assert property (jump_test_flags == xcvr_status_flags)
        else $error("jump flags differ");
    vector_low_a: assert property (vector_address[7:0] == vector_offset)
        else $error("vector low byte wrong");
    irq_gate_a: assert property (irq_sources == 5'h00 && bidir_irq_pin_oe |-> !irq_request)
        else $error("request without source");
endmodule // cbc_config_sva

// ### dv/tb.sv
`timescale 1ns/1ps
module tb
    import cbc_pkg::*;
;
    logic        clk, reset_n, reg_wr, reg_rd, reg_hit, exx_req, exx_a_alt, exx_b_alt, exx_busy, exx_done;
    logic        bank_a_alt, bank_b_alt, xcvr_wr, xcvr_rd, external_xcvr_clock_in, cpu_tstate_en;
    logic        xcvr_clock_en, clock_out_o, clock_out_oe, irq_request, bidir_irq_pin_i;
    logic        bidir_irq_pin_o, bidir_irq_pin_oe;
    logic [1:0]  exx_gie_op, xcvr_index, instr_wait_count;
    logic [2:0]  data_wait_count, irq_source_id;
    logic [4:0]  reg_addr, irq_sources;
    logic [7:0]  reg_wdata, reg_rdata, xcvr_status_flags, xcvr_rdata, xcvr_wdata, jump_test_flags, vector_offset;
    logic [15:0] vector_address;
    int          num_errors, checks_done, t, x;

    cbc_config_top uut (.*);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Errors %0d, checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
    endtask

    task automatic bank_exchange_instr(input logic a, input logic b, input logic [1:0] op, input int lim);
        int n;
        @(posedge clk);
        exx_req    <= 1'b1;
        exx_a_alt  <= a;
        exx_b_alt  <= b;
        exx_gie_op <= op;
        @(posedge clk);
        exx_req <= 1'b0;
        n = 0;
        #1;
        while (exx_done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 8) begin
            num_errors++;
            report_and_stop();
        end
        chk(n <= lim, 1'b1);
        @(posedge clk);
        #1 chk({bank_a_alt, bank_b_alt}, {a, b});
    endtask

    // Settle before counting, the external clock passes a synchroniser
    task automatic cnt(output int ct, output int cx);
        ct = 0;
        cx = 0;
        repeat (4) @(posedge clk);
        repeat (16) begin
            @(posedge clk);
            #1;
            ct += cpu_tstate_en;
            cx += xcvr_clock_en;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        external_xcvr_clock_in = 1'b0;
        forever #50 external_xcvr_clock_in = ~external_xcvr_clock_in;
    end

    initial begin
        num_errors = 0;
        checks_done = 0;
        {reset_n, reg_wr, reg_rd, exx_req, exx_a_alt, exx_b_alt} = '0;
        {reg_addr, reg_wdata, xcvr_rdata, irq_sources} = '0;
        exx_gie_op = CBC_GIE_KEEP;
        bidir_irq_pin_i = 1'b1;
        vector_offset = 8'h1C;
        xcvr_status_flags = 8'h5A;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        #1 chk({bank_a_alt, bank_b_alt}, 2'h3);
        chk({instr_wait_count, data_wait_count}, 5'h1F);
        chk(vector_address, 16'h001C);
        rd(5'h00);
        chk(reg_rdata, 8'h1F);
        rd(5'h01);
        chk(reg_rdata, 8'h00);
        wr(5'h01, 8'hA5);
        chk(vector_address, 16'hA51C);
        wr(5'h00, 8'h12);
        chk({instr_wait_count, data_wait_count}, 5'h12);
        for (int s = 0; s < 4; s++) begin
            wr(5'h00, {1'b0, s[1:0], 5'h1F});
            cnt(t, x);
            chk(t, 16);
            chk(x, s == 3 ? 4 : 16 >> s);
        end
        wr(5'h00, 8'h9F);
        cnt(t, x);
        chk(t, 8);
        chk(clock_out_o, clk);
        bank_exchange_instr(1'b1, 1'b1, CBC_GIE_KEEP, 4);
        wr(5'h00, 8'h1F);
        wr(5'h03, 8'h02);
        chk(clock_out_oe, 1'b0);
        @(posedge clk);
        irq_sources <= 5'h01;
        wr(5'h02, 8'h01);
        wr(5'h03, 8'h01);
        chk({irq_request, irq_source_id}, 4'h8);
        wr(5'h02, 8'h1E);
        chk(irq_request, 1'b0);
        wr(5'h02, 8'h01);
        bank_exchange_instr(1'b1, 1'b1, CBC_GIE_CLEAR, 1);
        chk(irq_request, 1'b0);
        bank_exchange_instr(1'b1, 1'b1, CBC_GIE_SET, 1);
        chk(irq_request, 1'b1);
        wr(5'h03, 8'h05);
        wr(5'h02, 8'h08);
        chk({bidir_irq_pin_oe, bidir_irq_pin_o, irq_request}, 3'h6);
        wr(5'h02, 8'h00);
        chk({bidir_irq_pin_oe, bidir_irq_pin_o}, 2'h2);
        wr(5'h03, 8'h01);
        @(posedge clk);
        irq_sources <= 5'h00;
        bidir_irq_pin_i <= 1'b0;
        wr(5'h02, 8'h08);
        repeat (3) @(posedge clk);
        #1 chk({irq_request, irq_source_id}, 4'hB);
        wr(5'h02, 8'h00);
        chk(irq_request, 1'b0);
        @(posedge clk);
        bidir_irq_pin_i <= 1'b1;
        bank_exchange_instr(1'b0, 1'b0, CBC_GIE_KEEP, 1);
        wr(5'h00, 8'hFF);
        rd(5'h00);
        chk(reg_rdata, 8'h5A);
        wr(5'h04, 8'h3C);
        wr(5'h08, 8'h22);
        rd(5'h04);
        chk(reg_rdata, 8'h3C);
        bank_exchange_instr(1'b0, 1'b1, CBC_GIE_KEEP, 1);
        wr(5'h08, 8'h11);
        rd(5'h08);
        chk(reg_rdata, 8'h11);
        @(posedge clk);
        xcvr_rdata <= 8'h99;
        rd(5'h05);
        chk(reg_rdata, 8'h99);
        bank_exchange_instr(1'b1, 1'b0, CBC_GIE_KEEP, 1);
        rd(5'h08);
        chk(reg_rdata, 8'h22);
        rd(5'h00);
        chk(reg_rdata, 8'h1F);
        rd(5'h0C);
        chk(reg_hit, 1'b0);
        report_and_stop();
    end
endmodule // tb

bind cbc_config_top cbc_config_sva sva (.*);
